/* File: design/plb_block.sv */
// module: logic block top with allocator, twelve macrocells, pin cells and APB configuration
//
// The APB register port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
module plb_block
	import plb_pkg::*;
(
	// clock and reset
	input wire logic REF_CLK_I,
	input wire logic RESET_N_I,
	// apb slave
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [11:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	output logic [31:0] PRDATA_O,
	output logic PREADY_O,
	output logic PSLVERR_O,
	// product-term array
	input wire logic [PLB_NUM_PT-1:0] PT_I,
	input wire logic [1:0] OE_PT_I,
	input wire logic ASYNC_RESET_PT_I,
	input wire logic ASYNC_PRESET_PT_I,
	// clock or gate pins
	input wire logic [PLB_NUM_CLK-1:0] CLK_PIN_I,
	output logic [PLB_NUM_CLK-1:0] CLK_DATA_O,
	// pin cells
	input wire logic [PLB_NUM_IO-1:0] IO_IN_I,
	output logic [PLB_NUM_IO-1:0] IO_OUT_O,
	output logic [PLB_NUM_IO-1:0] IO_OE_O,
	// internal feedback
	output logic [PLB_NUM_MC-1:0] FEEDBACK_O
);

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		plb_route_t [PLB_NUM_CL-1:0] route;
		plb_oe_t [PLB_NUM_IO-1:0] io_cfg;
		plb_mc_cfg_t [PLB_NUM_MC-1:0] mc_cfg;
		logic [PLB_NUM_CLK-1:0] clk_s1;
		logic [PLB_NUM_CLK-1:0] clk_s2;
		logic [PLB_NUM_CLK-1:0] clk_prev;
		logic [PLB_NUM_IO-1:0] io_s1;
		logic [PLB_NUM_IO-1:0] io_s2;
		logic [31:0] prdata;
		logic pslverr;
	} plb_state_t;

	localparam plb_state_t PLB_STATE_RST = '{
		route: {PLB_NUM_CL{PLB_ROUTE_RST}},
		io_cfg: {PLB_NUM_IO{PLB_IO_CFG_RST}},
		mc_cfg: {PLB_NUM_MC{PLB_MC_CFG_RST}},
		clk_s1: '0,
		clk_s2: '0,
		clk_prev: '0,
		io_s1: '0,
		io_s2: '0,
		prdata: '0,
		pslverr: 1'b0
	};

	plb_state_t s_q, s_d;
	logic [PLB_NUM_MC-1:0] sum;
	logic [PLB_NUM_MC-1:0] fb;
	plb_timing_t tim;
	plb_init_t init;
	logic [4:0] sel;

	// ****************************************
	// address decode
	// ****************************************
	function automatic logic [4:0] plb_decode(input logic [11:0] a);
		logic [11:0] off;
		off = a - PLB_ADDR_MC_BASE;
		if (a[1:0] != 2'b00) begin
			return PLB_SEL_NONE;
		end else if (a == PLB_ADDR_ROUTE0) begin
			return PLB_SEL_ROUTE0;
		end else if (a == PLB_ADDR_ROUTE1) begin
			return PLB_SEL_ROUTE1;
		end else if (a == PLB_ADDR_IO_CFG) begin
			return PLB_SEL_IO_CFG;
		end else if (a == PLB_ADDR_STATUS) begin
			return PLB_SEL_STATUS;
		end else if (a >= PLB_ADDR_MC_BASE && off[11:2] < 10'(PLB_NUM_MC)) begin
			return off[6:2];
		end
		return PLB_SEL_NONE;
	endfunction

	// ****************************************
	// shared timing and init terms
	// ****************************************
	// clock pins are sampled, so a pin edge reaches storage two to three cycles late
	always_comb begin
		tim.lvl = s_q.clk_s2;
		tim.rise = s_q.clk_s2 & ~s_q.clk_prev;
		init.reset = ASYNC_RESET_PT_I;
		init.preset = ASYNC_PRESET_PT_I;
	end

	// ****************************************
	// allocator and macrocells
	// ****************************************
	plb_alloc u_alloc (
		.pt_i(PT_I),
		.route_i(s_q.route),
		.sum_o(sum)
	);

	// even cells face pins; odd cells are buried and may sample pin k/2
	for (genvar k = 0; k < PLB_NUM_MC; k++) begin : g_mc
		plb_mcell u_mc (
			.clk_i(REF_CLK_I),
			.rst_n_i(RESET_N_I),
			.cfg_i(s_q.mc_cfg[k]),
			.sum_i(sum[k]),
			.pin_i((k % 2 == 1) ? s_q.io_s2[k/2] : 1'b0),
			.tim_i(tim),
			.init_i(init),
			.out_o(fb[k])
		);
	end

	// ****************************************
	// pin cells
	// ****************************************
	always_comb begin
		for (int p = 0; p < PLB_NUM_IO; p++) begin
			IO_OUT_O[p] = fb[2*p];
			unique case (s_q.io_cfg[p])
				PLB_OE_ON: IO_OE_O[p] = 1'b1;
				PLB_OE_OFF: IO_OE_O[p] = 1'b0;
				PLB_OE_PT0: IO_OE_O[p] = OE_PT_I[0];
				PLB_OE_PT1: IO_OE_O[p] = OE_PT_I[1];
				default: IO_OE_O[p] = 1'b0;
			endcase
		end
	end

	assign FEEDBACK_O = fb;
	assign CLK_DATA_O = s_q.clk_s2;

	// ****************************************
	// apb register file
	// ****************************************
	assign sel = plb_decode(PADDR_I);
	assign PREADY_O = 1'b1;
	assign PRDATA_O = s_q.prdata;
	assign PSLVERR_O = s_q.pslverr;

	always_comb begin
		s_d = s_q;
		s_d.clk_s1 = CLK_PIN_I;
		s_d.clk_s2 = s_q.clk_s1;
		s_d.clk_prev = s_q.clk_s2;
		s_d.io_s1 = IO_IN_I;
		s_d.io_s2 = s_q.io_s1;
		// read data and error are prepared in the setup cycle so they stand for the access
		if (PSEL_I && !PENABLE_I) begin
			s_d.prdata = '0;
			s_d.pslverr = (sel == PLB_SEL_NONE);
			if (!PWRITE_I) begin
				if (sel == PLB_SEL_ROUTE0) begin
					for (int c = 0; c < PLB_ROUTE_PER_REG; c++) begin
						s_d.prdata[c*PLB_ROUTE_FLD_W +: 3] = s_q.route[c];
					end
				end else if (sel == PLB_SEL_ROUTE1) begin
					for (int c = PLB_ROUTE_PER_REG; c < PLB_NUM_CL; c++) begin
						s_d.prdata[(c-PLB_ROUTE_PER_REG)*PLB_ROUTE_FLD_W +: 3] = s_q.route[c];
					end
				end else if (sel == PLB_SEL_IO_CFG) begin
					for (int p = 0; p < PLB_NUM_IO; p++) begin
						s_d.prdata[p*PLB_IO_FLD_W +: PLB_IO_FLD_W] = s_q.io_cfg[p];
					end
				end else if (sel == PLB_SEL_STATUS) begin
					s_d.prdata[PLB_STAT_FB_LSB +: PLB_NUM_MC] = fb;
					s_d.prdata[PLB_STAT_CLK_LSB +: PLB_NUM_CLK] = s_q.clk_s2;
					s_d.prdata[PLB_STAT_PIN_LSB +: PLB_NUM_IO] = s_q.io_s2;
				end else if (sel < 5'(PLB_NUM_MC)) begin
					s_d.prdata[8:0] = s_q.mc_cfg[sel[3:0]];
				end
			end
		end
		if (PSEL_I && PENABLE_I && PWRITE_I) begin
			if (sel == PLB_SEL_ROUTE0) begin
				for (int c = 0; c < PLB_ROUTE_PER_REG; c++) begin
					s_d.route[c] = plb_route_t'(PWDATA_I[c*PLB_ROUTE_FLD_W +: 3]);
				end
			end else if (sel == PLB_SEL_ROUTE1) begin
				for (int c = PLB_ROUTE_PER_REG; c < PLB_NUM_CL; c++) begin
					s_d.route[c] = plb_route_t'(PWDATA_I[(c-PLB_ROUTE_PER_REG)*PLB_ROUTE_FLD_W +: 3]);
				end
			end else if (sel == PLB_SEL_IO_CFG) begin
				for (int p = 0; p < PLB_NUM_IO; p++) begin
					s_d.io_cfg[p] = plb_oe_t'(PWDATA_I[p*PLB_IO_FLD_W +: PLB_IO_FLD_W]);
				end
			end else if (sel < 5'(PLB_NUM_MC)) begin
				s_d.mc_cfg[sel[3:0]] = plb_mc_cfg_t'(PWDATA_I[8:0]);
			end
		end
	end

	always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			s_q <= PLB_STATE_RST;
		end else begin
			s_q <= s_d;
		end
	end

endmodule

/* File: design/plb_pkg.sv */
// package: shared types, register map and reset values for the logic block
package plb_pkg;

	// ****************************************
	// geometry
	// ****************************************
	localparam int PLB_NUM_PT = 48;
	localparam int PLB_NUM_MC = 12;
	localparam int PLB_NUM_CL = 12;
	localparam int PLB_PT_PER_CL = 4;
	localparam int PLB_MAX_PT_PER_MC = 16;
	localparam int PLB_NUM_IO = 6;
	localparam int PLB_NUM_CLK = 4;
	localparam int PLB_CL_REACH_LO = 2;

	// ****************************************
	// configuration types
	// ****************************************
	typedef enum logic [4:0] {
		PLB_MC_COMB = 5'h01,
		PLB_MC_REG = 5'h02,
		PLB_MC_LATCH = 5'h04,
		PLB_MC_INREG = 5'h08,
		PLB_MC_INLATCH = 5'h10
	} plb_mode_t;

	typedef enum logic [3:0] {
		PLB_OE_ON = 4'h1,
		PLB_OE_OFF = 4'h2,
		PLB_OE_PT0 = 4'h4,
		PLB_OE_PT1 = 4'h8
	} plb_oe_t;

	typedef struct packed {
		logic [1:0] clk_sel;
		logic ttype;
		logic invert;
		plb_mode_t mode;
	} plb_mc_cfg_t;

	typedef struct packed {
		logic [1:0] sel;
		logic en;
	} plb_route_t;

	typedef struct packed {
		logic [3:0] lvl;
		logic [3:0] rise;
	} plb_timing_t;

	typedef struct packed {
		logic reset;
		logic preset;
	} plb_init_t;

	// ****************************************
	// register map (byte addresses)
	// ****************************************
	localparam logic [11:0] PLB_ADDR_ROUTE0 = 12'h000;
	localparam logic [11:0] PLB_ADDR_ROUTE1 = 12'h004;
	localparam logic [11:0] PLB_ADDR_IO_CFG = 12'h008;
	localparam logic [11:0] PLB_ADDR_STATUS = 12'h00C;
	localparam logic [11:0] PLB_ADDR_MC_BASE = 12'h040;

	localparam int PLB_ROUTE_FLD_W = 4;
	localparam int PLB_ROUTE_PER_REG = 8;
	localparam int PLB_IO_FLD_W = 4;
	localparam int PLB_STAT_FB_LSB = 0;
	localparam int PLB_STAT_CLK_LSB = 12;
	localparam int PLB_STAT_PIN_LSB = 16;

	localparam plb_route_t PLB_ROUTE_RST = 3'h0;
	localparam plb_mc_cfg_t PLB_MC_CFG_RST = 9'h001;
	localparam plb_oe_t PLB_IO_CFG_RST = PLB_OE_OFF;

	// ****************************************
	// decode codes
	// ****************************************
	localparam logic [4:0] PLB_SEL_ROUTE0 = 5'h0C;
	localparam logic [4:0] PLB_SEL_ROUTE1 = 5'h0D;
	localparam logic [4:0] PLB_SEL_IO_CFG = 5'h0E;
	localparam logic [4:0] PLB_SEL_STATUS = 5'h0F;
	localparam logic [4:0] PLB_SEL_NONE = 5'h1F;

	// cluster c may feed macrocell c-2+sel, so macrocell k sees clusters k-1..k+2
	function automatic logic plb_route_hits(input int c, input int k, input plb_route_t r);
		return r.en && ((c - PLB_CL_REACH_LO + int'(r.sel)) == k);
	endfunction

endpackage

/* File: design/plb_alloc.sv */
// module: product-term allocator steering clusters to macrocells
`timescale 1ns/100ps
module plb_alloc
	import plb_pkg::*;
(
	// product terms and steering
	input wire logic [PLB_NUM_PT-1:0] pt_i,
	input wire plb_route_t [PLB_NUM_CL-1:0] route_i,
	// per-macrocell sums
	output logic [PLB_NUM_MC-1:0] sum_o
);

	logic [PLB_NUM_CL-1:0] cl_or;

	// each cluster goes to at most one macrocell, so no term is ever shared twice
	always_comb begin
		sum_o = '0;
		for (int c = 0; c < PLB_NUM_CL; c++) begin
			cl_or[c] = |pt_i[c*PLB_PT_PER_CL +: PLB_PT_PER_CL];
		end
		for (int k = 0; k < PLB_NUM_MC; k++) begin
			for (int c = 0; c < PLB_NUM_CL; c++) begin
				if (plb_route_hits(c, k, route_i[c])) begin
					sum_o[k] = sum_o[k] | cl_or[c];
				end
			end
		end
	end

endmodule

/* File: design/plb_mcell.sv */
// module: one macrocell with combinational, register and latch modes
`timescale 1ns/100ps
module plb_mcell
	import plb_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// configuration
	input wire plb_mc_cfg_t cfg_i,
	// data sources
	input wire logic sum_i,
	input wire logic pin_i,
	input wire plb_timing_t tim_i,
	input wire plb_init_t init_i,
	// result
	output logic out_o
);

	typedef struct packed {
		logic q;
	} plb_mc_state_t;

	plb_mc_state_t s_q, s_d;
	logic f;
	logic src;
	logic gate;
	logic rise;
	logic is_in;
	logic is_latch;
	logic stored;

	always_comb begin
		s_d = s_q;
		f = sum_i ^ cfg_i.invert;
		is_in = (cfg_i.mode == PLB_MC_INREG) || (cfg_i.mode == PLB_MC_INLATCH);
		is_latch = (cfg_i.mode == PLB_MC_LATCH) || (cfg_i.mode == PLB_MC_INLATCH);
		src = is_in ? pin_i : f;
		gate = tim_i.lvl[cfg_i.clk_sel];
		rise = tim_i.rise[cfg_i.clk_sel];
		stored = 1'b1;
		unique case (cfg_i.mode)
			PLB_MC_REG, PLB_MC_INREG: begin
				if (rise) begin
					if (cfg_i.ttype && cfg_i.mode == PLB_MC_REG) begin
						s_d.q = s_q.q ^ src;
					end else begin
						s_d.q = src;
					end
				end
			end
			PLB_MC_LATCH, PLB_MC_INLATCH: begin
				if (!gate) begin
					s_d.q = src;
				end
			end
			PLB_MC_COMB: begin
				stored = 1'b0;
			end
			default: begin
				stored = 1'b0;
			end
		endcase
		// the shared terms override any clock; reset wins over preset
		if (init_i.reset) begin
			s_d.q = 1'b0;
		end else if (init_i.preset) begin
			s_d.q = 1'b1;
		end
		// the same result drives the pin and the feedback path
		if (!stored) begin
			out_o = f;
		end else if (init_i.reset) begin
			out_o = 1'b0;
		end else if (init_i.preset) begin
			out_o = 1'b1;
		end else if (is_latch && !gate) begin
			out_o = src;
		end else begin
			out_o = s_q.q;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

endmodule

/* File: testbench/plb_block_sva.sv */
// checker: port-level assertions for the logic block
`timescale 1ns/100ps
module plb_chk
	import plb_pkg::*;
(
	input wire logic REF_CLK_I,
	input wire logic RESET_N_I,
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [11:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	input wire logic [31:0] PRDATA_O,
	input wire logic PREADY_O,
	input wire logic PSLVERR_O,
	input wire logic [1:0] OE_PT_I,
	input wire logic [3:0] CLK_PIN_I,
	input wire logic [3:0] CLK_DATA_O,
	input wire logic [5:0] IO_OUT_O,
	input wire logic [5:0] IO_OE_O,
	input wire logic [11:0] FEEDBACK_O
);
	default clocking @(posedge REF_CLK_I); endclocking
	default disable iff (!RESET_N_I);
	logic setup;
	logic bad;
	logic acc_io;
	assign setup = PSEL_I && !PENABLE_I;
	assign bad = PADDR_I[1:0] != 2'h0 || (PADDR_I > 12'h00C && PADDR_I < 12'h040) || PADDR_I > 12'h06C;
	assign acc_io = PSEL_I && PENABLE_I && PWRITE_I && PADDR_I == PLB_ADDR_IO_CFG;
	property p_ready; PREADY_O; endproperty
	a_ready: assert property (p_ready) else $error("ready low");
	property p_err; setup && bad |=> PSLVERR_O; endproperty
	a_err: assert property (p_err) else $error("bad address not refused");
	property p_ok; setup && !bad |=> !PSLVERR_O; endproperty
	a_ok: assert property (p_ok) else $error("good address refused");
	property p_hold; PSEL_I && PENABLE_I |=> $stable(PRDATA_O) && $stable(PSLVERR_O); endproperty
	a_hold: assert property (p_hold) else $error("read data moved");
	property p_sync; $past(RESET_N_I) && $past(RESET_N_I, 2) |-> CLK_DATA_O == $past(CLK_PIN_I, 2); endproperty
	a_sync: assert property (p_sync) else $error("clock pin data wrong");
	property p_oe; acc_io |=> IO_OE_O[0] == ($past(PWDATA_I[3:0]) == 4'h1
		|| $past(PWDATA_I[3:0]) == 4'h4 && OE_PT_I[0] || $past(PWDATA_I[3:0]) == 4'h8 && OE_PT_I[1]); endproperty
	a_oe: assert property (p_oe) else $error("pin enable wrong");
	property p_pin; IO_OUT_O == {FEEDBACK_O[10], FEEDBACK_O[8], FEEDBACK_O[6], FEEDBACK_O[4], FEEDBACK_O[2],
		FEEDBACK_O[0]}; endproperty
	a_pin: assert property (p_pin) else $error("pin not from even cell");
	property p_stat; setup && !PWRITE_I && PADDR_I == PLB_ADDR_STATUS |=>
		PRDATA_O[15:0] == {$past(CLK_DATA_O), $past(FEEDBACK_O)} && PRDATA_O[31:22] == 10'h0; endproperty
	a_stat: assert property (p_stat) else $error("status wrong");
endmodule
bind plb_block plb_chk u_chk (.REF_CLK_I, .RESET_N_I, .PSEL_I, .PENABLE_I, .PWRITE_I, .PADDR_I, .PWDATA_I,
	.PRDATA_O, .PREADY_O, .PSLVERR_O, .OE_PT_I, .CLK_PIN_I, .CLK_DATA_O, .IO_OUT_O, .IO_OE_O, .FEEDBACK_O);

/* File: testbench/plb_board.sv */
// partner: board drivers on the shared pins
`timescale 1ns/100ps
module plb_board (
	// device side
	input wire logic [5:0] dev_out_i,
	input wire logic [5:0] dev_oe_i,
	// board drivers
	input wire logic [5:0] drv_en_i,
	input wire logic [5:0] drv_val_i,
	// resolved level
	output logic [5:0] pin_o
);
	// undriven pins float high through the pull-ups
	assign pin_o = (dev_oe_i & dev_out_i) | (~dev_oe_i & drv_en_i & drv_val_i) | (~dev_oe_i & ~drv_en_i);
endmodule

/* File: testbench/tb_top.sv */
// testbench: apb-driven scenarios for the logic block
`timescale 1ns/100ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin failures++; $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module tb_top
	import plb_pkg::*;
;
	logic clk, rst_n, psel, pen, pwr, ares, apre, err;
	logic [11:0] paddr, fb;
	logic [31:0] pwdata, prdata, rd;
	logic pready, perr;
	logic [47:0] pt;
	logic [1:0] oe_pt;
	logic [3:0] cpin, cdata;
	logic [5:0] pins, iout, ioe, den, dval;
	int failures, num_checks, cyc;
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	plb_block dut (.REF_CLK_I(clk), .RESET_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
		.PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(perr),
		.PT_I(pt), .OE_PT_I(oe_pt), .ASYNC_RESET_PT_I(ares), .ASYNC_PRESET_PT_I(apre), .CLK_PIN_I(cpin),
		.CLK_DATA_O(cdata), .IO_IN_I(pins), .IO_OUT_O(iout), .IO_OE_O(ioe), .FEEDBACK_O(fb));
	plb_board u_board (.dev_out_i(iout), .dev_oe_i(ioe), .drv_en_i(den), .drv_val_i(dval), .pin_o(pins));
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			failures++;
			give_verdict();
		end
		rd = prdata;
		err = perr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		`CHK("rdata", e, rd)
		`CHK("slverr", 1'b0, err)
	endtask
	task automatic fbk(input int i, input logic e);
		wt(4);
		`CHK("feedback", e, fb[i])
	endtask
	task automatic pin(input int i, input logic v);
		cpin[i] <= v;
		wt(6);
	endtask
	task automatic rchk(input logic [31:0] r0, input logic [31:0] r1, input logic [47:0] p, input logic [11:0] e);
		wr(PLB_ADDR_ROUTE0, r0);
		wr(PLB_ADDR_ROUTE1, r1);
		pt <= p;
		wt(2);
		`CHK("sums", e, fb)
	endtask
	task automatic give_verdict();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// hang guard: the whole sequence needs a few hundred cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc > 20000) begin
			failures++;
			give_verdict();
		end
	end
	initial begin
		{rst_n, psel, pen, pwr, ares, apre, paddr, pwdata, pt, oe_pt, cpin, den, dval} = '0;
		wt(20);
		rst_n <= 1'b1;
		rdc(PLB_ADDR_IO_CFG, 32'h00222222);
		rdc(PLB_ADDR_MC_BASE, 32'h1);
		apb(1'b0, 12'h010, 32'h0);
		`CHK("unmapped", 1'b1, err)
		wr(PLB_ADDR_IO_CFG, 32'h00111111);
		rchk(32'h5, 32'h0, 48'h1, 12'h001);
		`CHK("pin", 1'b1, iout[0])
		wr(PLB_ADDR_MC_BASE, 32'h21);
		fbk(0, 1'b0);
		wr(PLB_ADDR_MC_BASE, 32'h1);
		for (int s = 0; s < 4; s++) rchk(32'(1 + 2 * s) << 12, 32'h0, 48'h1000, 12'h1 << (1 + s));
		rchk(32'h3, 32'h0, 48'h1, 12'h0);
		rchk(32'h0, 32'h7000, 48'h1 << 44, 12'h0);
		rchk(32'h0, 32'h5000, 48'h1 << 44, 12'h800);
		for (int i = 16; i < 33; i++) rchk(32'h13570000, 32'h0, 48'h1 << i, i < 32 ? 12'h020 : 12'h0);
		rchk(32'h5, 32'h0, 48'h1, 12'h001);
		wr(PLB_ADDR_MC_BASE, 32'h2);
		fbk(0, 1'b0);
		pin(0, 1'b1);
		fbk(0, 1'b1);
		pt <= 48'h0;
		pin(0, 1'b0);
		fbk(0, 1'b1);
		wr(PLB_ADDR_MC_BASE, 32'h82);
		pin(0, 1'b1);
		pin(0, 1'b0);
		fbk(0, 1'b1);
		pin(1, 1'b1);
		`CHK("clkdata", 4'h2, cdata)
		fbk(0, 1'b0);
		pin(1, 1'b0);
		wr(PLB_ADDR_MC_BASE + 12'h8, 32'h2);
		apre <= 1'b1;
		wt(2);
		`CHK("preset", 2'h3, {fb[2], fb[0]})
		ares <= 1'b1;
		wt(2);
		`CHK("reset", 2'h0, {fb[2], fb[0]})
		ares <= 1'b0;
		apre <= 1'b0;
		wr(PLB_ADDR_MC_BASE, 32'h42);
		pt <= 48'h1;
		for (int t = 0; t < 3; t++) begin
			if (t == 2) pt <= 48'h0;
			pin(0, 1'b1);
			pin(0, 1'b0);
			fbk(0, t == 0);
		end
		wr(PLB_ADDR_MC_BASE, 32'h4);
		pt <= 48'h1;
		fbk(0, 1'b1);
		pin(0, 1'b1);
		pt <= 48'h0;
		fbk(0, 1'b1);
		pin(0, 1'b0);
		fbk(0, 1'b0);
		wr(PLB_ADDR_IO_CFG, 32'h00111112);
		wr(PLB_ADDR_MC_BASE + 12'h4, 32'h8);
		den <= 6'h3F;
		dval <= 6'h1;
		fbk(1, 1'b0);
		pin(0, 1'b1);
		pin(0, 1'b0);
		fbk(1, 1'b1);
		wr(PLB_ADDR_MC_BASE + 12'h4, 32'h10);
		dval <= 6'h0;
		fbk(1, 1'b0);
		for (int c = 0; c < 5; c++) begin
			for (int o = 0; o < 2; o++) begin
				wr(PLB_ADDR_IO_CFG, c < 4 ? 32'h1 << c : 32'h3);
				oe_pt <= o ? 2'h1 : 2'h2;
				wt(2);
				`CHK("oe", c == 0 || c == 2 && o || c == 3 && !o, ioe[0])
			end
		end
		cpin <= 4'h4;
		dval <= 6'h2A;
		wt(4);
		apb(1'b0, PLB_ADDR_STATUS, 32'h0);
		`CHK("status", 10'h2A4, rd[21:12])
		give_verdict();
	end
endmodule
